// >>> hw/fcl_consts.svh
// fcl_consts.svh: constants for the configuration loader (scheme codes, timing)
// assumes a 10 MHz system clock; included by the package and the design modules
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH

`define FCL_BYTE_W          8
`define FCL_SCHEME_W        3
`define FCL_SCHEME_STREAM   3'b110
`define FCL_SCHEME_FAST_AS  3'b001
`define FCL_SCHEME_JTAG     3'b111
`define FCL_PAGE_FACTORY    1'b1
`define FCL_PAGE_USER       1'b0
`define FCL_FIFO_DEPTH      16
`define FCL_FIFO_AW         4
`define FCL_CLK_PERIOD_NS   100
`define FCL_DONE_WAIT_NS    1000000
`define FCL_DONE_WAIT_CYC   (`FCL_DONE_WAIT_NS / `FCL_CLK_PERIOD_NS)
`define FCL_WAIT_CNT_W      24

`endif

// >>> hw/fcl_pkg.sv
// fcl_pkg: types shared by the configuration loader modules
// assumes fcl_consts.svh is on the include path
`include "fcl_consts.svh"

package fcl_pkg;

   // one streamed byte plus its end-of-image marker
   typedef struct packed {
      logic                   last;
      logic [`FCL_BYTE_W-1:0] data;
   } fcl_beat_t;

   typedef enum logic [2:0] {
      FCL_SAMPLE,
      FCL_IDLE,
      FCL_START,
      FCL_LOAD,
      FCL_WAIT_DONE,
      FCL_DONE,
      FCL_ERROR
   } fcl_state_t;

endpackage : fcl_pkg

// >>> hw/fcl_fifo.sv
// fcl_fifo: flip-flop FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset; full and empty are flops
`include "fcl_consts.svh"

module fcl_fifo
   import fcl_pkg::*;
#(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = `FCL_FIFO_DEPTH,
   parameter int unsigned AW    = `FCL_FIFO_AW
) (
   input  wire logic             i_clock,    // system clock
   input  wire logic             i_sys_rst,  // sync reset, high
   input  wire logic             i_wr_valid, // write offered
   input  wire logic [WIDTH-1:0] i_wr_data,  // write word
   output logic                  o_wr_ready, // room for a word
   output logic                  o_rd_valid, // word available
   output logic      [WIDTH-1:0] o_rd_data,  // head word
   input  wire logic             i_rd_ready  // head word taken
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
      logic                        full;
      logic                        empty;
   } fcl_fifo_st_t;

   fcl_fifo_st_t st_r;
   fcl_fifo_st_t st_nxt;
   logic         push;
   logic         pop;

   // handshakes use the registered flags so ready never depends on the reader
   assign push       = i_wr_valid && !st_r.full;
   assign pop        = i_rd_ready && !st_r.empty;
   assign o_wr_ready = !st_r.full;
   assign o_rd_valid = !st_r.empty;
   assign o_rd_data  = st_r.mem[st_r.rd_ptr];

   // pointer and occupancy update
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = i_wr_data;
         st_nxt.wr_ptr           = st_r.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
      st_nxt.full  = (st_nxt.count == (AW+1)'(DEPTH));
      st_nxt.empty = (st_nxt.count == '0);
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         st_r       <= '0;
         st_r.empty <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // fcl_fifo

// >>> hw/fcl_loader.sv
// fcl_loader: board configuration loader, flash byte stream into the fpga stream port
// assumes flash bytes arrive only after o_flash_start, and the fpga reports done/error
`include "fcl_consts.svh"

module fcl_loader
   import fcl_pkg::*;
#(
   parameter int unsigned DONE_WAIT_CYC = `FCL_DONE_WAIT_CYC
) (
   input  wire logic                     i_clock,                  // 10 MHz system clock
   input  wire logic                     i_sys_rst,                // sync reset, high
   input  wire logic [`FCL_SCHEME_W-1:0] i_config_scheme_select,   // scheme strap
   input  wire logic                     i_factory_image_select,   // 1 factory, 0 user
   output logic                          o_flash_start,            // one-cycle read request
   output logic                          o_flash_page,             // page to read
   input  wire logic                     i_flash_valid,            // flash byte valid
   input  wire logic [`FCL_BYTE_W-1:0]   i_flash_data,             // flash byte
   input  wire logic                     i_flash_last,             // last image byte
   output logic                          o_flash_ready,            // loader takes byte
   output logic                          o_cfg_valid,              // stream byte valid
   output logic [`FCL_BYTE_W-1:0]        o_cfg_data,               // stream byte
   input  wire logic                     i_cfg_ready,              // fpga takes byte
   input  wire logic                     i_fpga_conf_done,         // fpga reports done
   input  wire logic                     i_fpga_cfg_error,         // fpga reports error
   output logic                          o_load_active,            // loading indicator
   output logic                          o_load_error,             // error indicator
   output logic                          o_config_done_indicator_n, // done, active low
   output logic                          o_factory_page            // factory boot indicator
);

   typedef struct packed {
      fcl_state_t                 state;
      logic [`FCL_SCHEME_W-1:0]   scheme;
      logic                       page;
      logic                       start;
      fcl_beat_t                  out;
      logic                       out_valid;
      logic                       load;
      logic                       err;
      logic                       done_n;
      logic                       factory;
      logic [`FCL_WAIT_CNT_W-1:0] wait_cnt;
   } fcl_loader_st_t;

   fcl_loader_st_t st_r;
   fcl_loader_st_t st_nxt;
   fcl_beat_t      fifo_in;
   fcl_beat_t      fifo_out;
   logic           fifo_wr_ready;
   logic           fifo_rd_valid;
   logic           fifo_pop;
   logic           out_take;

   // decode of the strap, used by the sequencer and its checks
   function automatic logic is_stream(input logic [`FCL_SCHEME_W-1:0] s);
      return s == `FCL_SCHEME_STREAM;
   endfunction

   assign fifo_in.data = i_flash_data;
   assign fifo_in.last = i_flash_last;
   assign out_take     = st_r.out_valid && i_cfg_ready;
   // the output stage refills when empty or when its byte leaves this cycle
   assign fifo_pop     = (st_r.state == FCL_LOAD) && fifo_rd_valid
                         && (!st_r.out_valid || i_cfg_ready);

   fcl_fifo #(
      .WIDTH ($bits(fcl_beat_t)),
      .DEPTH (`FCL_FIFO_DEPTH),
      .AW    (`FCL_FIFO_AW)
   ) u_fifo (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_wr_valid (i_flash_valid),
      .i_wr_data  (fifo_in),
      .o_wr_ready (fifo_wr_ready),
      .o_rd_valid (fifo_rd_valid),
      .o_rd_data  (fifo_out),
      .i_rd_ready (fifo_pop)
   );

   // sequencer: sample straps once, then fetch, stream, wait for the fpga verdict
   always_comb begin
      st_nxt       = st_r;
      st_nxt.start = 1'b0;
      if (out_take) begin
         st_nxt.out_valid = 1'b0;
      end
      if (fifo_pop) begin
         st_nxt.out       = fifo_out;
         st_nxt.out_valid = 1'b1;
      end
      case (st_r.state)
         FCL_SAMPLE: begin
            st_nxt.scheme = i_config_scheme_select;
            st_nxt.page   = i_factory_image_select;
            if (is_stream(i_config_scheme_select)) begin
               st_nxt.start = 1'b1;
               st_nxt.load  = 1'b1;
               st_nxt.state = FCL_START;
            end else begin
               // fast serial and jtag: the fpga owns its config, we stay quiet
               st_nxt.state = FCL_IDLE;
            end
         end
         FCL_IDLE: begin
            st_nxt.state = FCL_IDLE;
         end
         FCL_START: begin
            st_nxt.state = FCL_LOAD;
         end
         FCL_LOAD: begin
            if (i_fpga_cfg_error) begin
               st_nxt.state     = FCL_ERROR;
               st_nxt.load      = 1'b0;
               st_nxt.err       = 1'b1;
               st_nxt.out_valid = 1'b0;
            end else if (out_take && st_r.out.last) begin
               st_nxt.state    = FCL_WAIT_DONE;
               st_nxt.load     = 1'b0;
               st_nxt.wait_cnt = '0;
            end
         end
         FCL_WAIT_DONE: begin
            st_nxt.wait_cnt = st_r.wait_cnt + 1'b1;
            if (i_fpga_cfg_error) begin
               st_nxt.state = FCL_ERROR;
               st_nxt.err   = 1'b1;
            end else if (i_fpga_conf_done) begin
               st_nxt.state   = FCL_DONE;
               st_nxt.done_n  = 1'b0;
               st_nxt.factory = (st_r.page == `FCL_PAGE_FACTORY);
            end else if (st_r.wait_cnt == `FCL_WAIT_CNT_W'(DONE_WAIT_CYC - 1)) begin
               // no done from the fpga in time counts as a failed attempt
               st_nxt.state = FCL_ERROR;
               st_nxt.err   = 1'b1;
            end
         end
         FCL_DONE: begin
            st_nxt.state = FCL_DONE;
         end
         FCL_ERROR: begin
            st_nxt.state = FCL_ERROR;
         end
         default: begin
            st_nxt.state = FCL_SAMPLE;
         end
      endcase
   end

   // straps are caught by the first clocked cycle after reset, never by reset itself
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         st_r        <= '0;
         st_r.state  <= FCL_SAMPLE;
         st_r.page   <= `FCL_PAGE_FACTORY;
         st_r.done_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output is a flop; the fifo ready is its registered full flag
   assign o_flash_start             = st_r.start;
   assign o_flash_page              = st_r.page;
   assign o_flash_ready             = fifo_wr_ready;
   assign o_cfg_valid               = st_r.out_valid;
   assign o_cfg_data                = st_r.out.data;
   assign o_load_active             = st_r.load;
   assign o_load_error              = st_r.err;
   assign o_config_done_indicator_n = st_r.done_n;
   assign o_factory_page            = st_r.factory;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   a_quiet_non_stream: assert property (
      (st_r.state != FCL_SAMPLE && !is_stream(st_r.scheme))
      |-> !o_load_active && !o_flash_start && !o_cfg_valid && o_config_done_indicator_n)
      else $error("loader active outside streaming scheme");
   a_jtag_hands_off: assert property (
      st_r.scheme == `FCL_SCHEME_JTAG && st_r.state != FCL_SAMPLE |-> !o_cfg_valid)
      else $error("stream driven in jtag scheme");
   a_start_loads: assert property (
      o_flash_start |=> o_load_active [*2])
      else $error("fetch not followed by load");
   a_page_follows_sw: assert property (
      o_flash_start |-> o_flash_page == $past(i_factory_image_select))
      else $error("wrong flash page requested");
   // an fpga error may drop a waiting byte, so only the error-free hold is checked
   a_byte_holds: assert property (
      o_cfg_valid && !i_cfg_ready && !i_fpga_cfg_error |=> o_cfg_valid && $stable(o_cfg_data))
      else $error("stream byte dropped under back-pressure");
   a_last_ends_load: assert property (
      o_load_active && out_take && st_r.out.last && !i_fpga_cfg_error |=> !o_load_active)
      else $error("load indicator outlived the image");
   a_err_on_fail: assert property (
      o_load_active && i_fpga_cfg_error |=> o_load_error && !o_load_active)
      else $error("fpga error not flagged");
   a_done_cause: assert property (
      $fell(o_config_done_indicator_n) |-> $past(i_fpga_conf_done) && !o_load_error)
      else $error("done lit without fpga done");
   a_factory_led: assert property (
      o_factory_page |-> !o_config_done_indicator_n && o_flash_page == `FCL_PAGE_FACTORY)
      else $error("factory indicator without factory boot");
   a_fast_as_idle: assert property (
      st_r.scheme == `FCL_SCHEME_FAST_AS && st_r.state != FCL_SAMPLE
      |-> st_r.state == FCL_IDLE)
      else $error("loader acting in fast active serial");

   c_load_done:    cover property ($fell(o_config_done_indicator_n));
   c_load_error:   cover property ($rose(o_load_error));
   c_backpressure: cover property (o_cfg_valid && !i_cfg_ready && !o_flash_ready);
   c_user_page:    cover property (o_flash_start && o_flash_page == `FCL_PAGE_USER);

endmodule // fcl_loader

// >>> sim/fcl_far_end_model.sv
// fcl_far_end_model: flash image source and fpga stream sink facing the loader
// assumes the bench sets its controls while reset is held
module fcl_far_end_model (
   input  wire logic       i_clock,       // system clock
   input  wire logic       i_sys_rst,     // sync reset, high
   input  wire logic       i_flash_start, // read request
   input  wire logic       i_flash_page,  // page to read
   input  wire logic       i_flash_ready, // loader takes byte
   output logic            o_flash_valid, // byte offered
   output logic [7:0]      o_flash_data,  // image byte
   output logic            o_flash_last,  // final byte
   input  wire logic       i_cfg_valid,   // stream byte valid
   input  wire logic [7:0] i_cfg_data,    // stream byte
   output logic            o_cfg_ready,   // sink takes byte
   output logic            o_conf_done,   // configured
   output logic            o_cfg_error,   // configuration failed
   input  wire logic [7:0] i_len,         // image length
   input  wire logic       i_stall,       // take one byte in eight
   input  wire logic [7:0] i_err_at,      // failing byte count, 0 none
   input  wire logic       i_no_done,     // never report done
   output logic [7:0]      o_rx_cnt,      // bytes taken
   output logic            o_rx_bad       // byte out of order
);
   logic       busy;
   logic       page;
   logic [7:0] sent;
   logic [7:0] nxt;
   logic [2:0] cyc;

   // count of bytes the loader has taken, including the one taken at this edge
   assign nxt = sent + {7'h00, o_flash_valid & i_flash_ready};

   // bit 7 of each byte carries the requested page, and the sink expects that same page back
   always @(posedge i_clock) begin
      cyc <= cyc + 3'h1;
      if (i_sys_rst) begin
         cyc <= 3'h0;
         busy <= 1'b0;
         sent <= 8'h00;
         o_flash_valid <= 1'b0;
         o_flash_data <= 8'h00;
         o_flash_last <= 1'b0;
         o_cfg_ready <= 1'b0;
         o_conf_done <= 1'b0;
         o_cfg_error <= 1'b0;
         o_rx_cnt <= 8'h00;
         o_rx_bad <= 1'b0;
      end else begin
         sent <= nxt;
         if (i_flash_start) begin
            busy <= 1'b1;
            page <= i_flash_page;
         end
         // released data toggles so a stale byte never looks valid
         if (busy && nxt < i_len) begin
            o_flash_valid <= 1'b1;
            o_flash_data <= {page, nxt[6:0]};
            o_flash_last <= (nxt == i_len - 8'h01);
         end else begin
            o_flash_valid <= 1'b0;
            o_flash_data <= ~o_flash_data;
            o_flash_last <= 1'b0;
         end
         o_cfg_ready <= !i_stall || (cyc == 3'h0);
         if (i_cfg_valid && o_cfg_ready) begin
            o_rx_cnt <= o_rx_cnt + 8'h01;
            if (i_cfg_data !== {page, o_rx_cnt[6:0]}) o_rx_bad <= 1'b1;
            if (o_rx_cnt + 8'h01 == i_err_at) o_cfg_error <= 1'b1;
            if (o_rx_cnt + 8'h01 == i_len && !i_no_done) o_conf_done <= 1'b1;
         end
      end
   end
endmodule // fcl_far_end_model

// >>> sim/test_fpga_config_loader.sv
// test_fpga_config_loader: self-checking bench for the configuration loader
// assumes fcl_far_end_model stands for the flash and the fpga stream port
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch at %0t ns: %s", $time, m); end end

module test_fpga_config_loader;
   timeunit 1ns;
   timeprecision 1ns;
   int         miscompares = 0;
   int         comparisons = 0;
   logic       i_clock, i_sys_rst, sel, fv, fl, fr, cv, cr, done, err, start, page;
   logic       act, lerr, done_n, fac, stall, no_done, rx_bad, seen, full, act_bad;
   logic [2:0] scheme;
   logic [7:0] fd, cd, len, err_at, rx;

   // done wait shortened to 20 cycles to keep the timeout case brief
   fcl_loader #(.DONE_WAIT_CYC(20)) dut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_config_scheme_select(scheme),
      .i_factory_image_select(sel), .o_flash_start(start), .o_flash_page(page),
      .i_flash_valid(fv), .i_flash_data(fd), .i_flash_last(fl), .o_flash_ready(fr),
      .o_cfg_valid(cv), .o_cfg_data(cd), .i_cfg_ready(cr), .i_fpga_conf_done(done),
      .i_fpga_cfg_error(err), .o_load_active(act), .o_load_error(lerr),
      .o_config_done_indicator_n(done_n), .o_factory_page(fac));

   fcl_far_end_model far (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_flash_start(start), .i_flash_page(page),
      .i_flash_ready(fr), .o_flash_valid(fv), .o_flash_data(fd), .o_flash_last(fl),
      .i_cfg_valid(cv), .i_cfg_data(cd), .o_cfg_ready(cr), .o_conf_done(done),
      .o_cfg_error(err), .i_len(len), .i_stall(stall), .i_err_at(err_at),
      .i_no_done(no_done), .o_rx_cnt(rx), .o_rx_bad(rx_bad));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // sticky observations, cleared while reset is held
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         seen <= 1'b0;
         full <= 1'b0;
         act_bad <= 1'b0;
      end else begin
         if (start) seen <= 1'b1;
         if (!fr) full <= 1'b1;
         if (cv && cr && !act) act_bad <= 1'b1;
      end
   end

   task automatic wrap_up;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] s, input logic p, input logic [7:0] n,
                           input logic st, input logic [7:0] ea, input logic nd);
      @(posedge i_clock);
      i_sys_rst <= 1'b1;
      {scheme, sel, len, stall, err_at, no_done} <= {s, p, n, st, ea, nd};
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
   endtask

   // bounded wait for done or error
   task automatic wait_verdict;
      int k;
      k = 0;
      while (done_n !== 1'b0 && lerr !== 1'b1 && k < 2000) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      `CHK(k < 2000, 1'b1, "no verdict")
   endtask

   task automatic t_load(input logic p, input logic st);
      int k;
      do_reset(3'h6, p, 8'h28, st, 8'h00, 1'b0);
      k = 0;
      while (start !== 1'b1 && k < 4) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      `CHK(start, 1'b1, "no start pulse")
      `CHK(page, p, "wrong page")
      `CHK(act, 1'b1, "not active at start")
      wait_verdict;
      `CHK(rx, 8'h28, "byte count")
      `CHK(rx_bad, 1'b0, "byte order or page")
      `CHK({done_n, lerr, act}, 3'h0, "done, error or active wrong")
      `CHK(fac, p, "factory indicator")
      `CHK(act_bad, 1'b0, "byte moved while inactive")
      if (st) `CHK(full, 1'b1, "fifo never filled")
   endtask

   // a late strap change to streaming must not start a load
   task automatic t_idle(input logic [2:0] s);
      do_reset(s, 1'b1, 8'h08, 1'b0, 8'h00, 1'b0);
      repeat (5) @(posedge i_clock);
      scheme <= 3'h6;
      repeat (40) @(posedge i_clock);
      #1;
      `CHK(seen, 1'b0, "start outside streaming")
      `CHK(cv, 1'b0, "stream driven")
      `CHK({act, lerr, done_n, fac}, 4'h2, "indicators not off")
   endtask

   task automatic t_error;
      logic [7:0] n;
      do_reset(3'h6, 1'b1, 8'h28, 1'b1, 8'h0a, 1'b0);
      wait_verdict;
      @(posedge i_clock);
      #1;
      n = rx;
      `CHK({lerr, done_n, act, cv, fac}, 5'h18, "error verdict")
      repeat (30) @(posedge i_clock);
      #1;
      `CHK(rx, n, "stream went on after error")
   endtask

   // the error must come exactly 20 cycles (the shortened done wait) after the last byte
   task automatic t_timeout;
      int k;
      do_reset(3'h6, 1'b0, 8'h08, 1'b0, 8'h00, 1'b1);
      k = 0;
      while (rx !== 8'h08 && k < 200) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      k = 0;
      while (lerr !== 1'b1 && k < 40) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      `CHK(k, 20, "done wait length")
      wait_verdict;
      `CHK({lerr, done_n, fac, rx}, 11'h608, "timeout verdict")
   endtask

   initial begin
      i_sys_rst <= 1'b1;
      {scheme, sel, len, stall, err_at, no_done} <= {3'h6, 1'b1, 8'h00, 1'b0, 8'h00, 1'b0};
      t_load(1'b1, 1'b1);
      t_load(1'b0, 1'b0);
      t_idle(3'h1);
      t_idle(3'h7);
      t_idle(3'h0);
      t_error;
      t_timeout;
      wrap_up;
   end

   // watchdog well beyond the several hundred cycles the cases need
   initial begin
      #3000000;
      miscompares++;
      wrap_up;
   end
endmodule // test_fpga_config_loader
